// file: src/dmac_regs.svh
// Register offsets, field positions, reset values and trigger codes for
// the DMA channel address, trigger and count block.
// Assumes an 8-bit register port with byte offsets within the channel.
`ifndef DMAC_REGS_SVH
`define DMAC_REGS_SVH

// Register offsets within the channel.
`define DMAC_OFS_ADDR_CTRL 4'h2
`define DMAC_OFS_TRIG_SEL 4'h3
`define DMAC_OFS_CNT_LOW 4'h4
`define DMAC_OFS_CNT_HIGH 4'h5
`define DMAC_OFS_SRC_LOW 4'h8
`define DMAC_OFS_SRC_HIGH 4'h9
`define DMAC_OFS_DST_LOW 4'hC
`define DMAC_OFS_DST_HIGH 4'hD
// Status register holding the busy bit and the selected request level.
`define DMAC_OFS_STATUS 4'hE

// Field positions in the address control register.
`define DMAC_SRC_RELOAD_HI 7
`define DMAC_SRC_RELOAD_LO 6
`define DMAC_SRC_STEP_HI 5
`define DMAC_SRC_STEP_LO 4
`define DMAC_DST_RELOAD_HI 3
`define DMAC_DST_RELOAD_LO 2
`define DMAC_DST_STEP_HI 1
`define DMAC_DST_STEP_LO 0

// Reset values.
`define DMAC_RST_ADDR_CTRL 8'h00
`define DMAC_RST_TRIG_SEL 8'h00
`define DMAC_RST_COUNT 16'h0001
`define DMAC_RST_ADDR 16'h0000

// Trigger base codes and offsets.
`define DMAC_TRIG_OFF 8'h00
`define DMAC_TRIG_EVENT 8'h01
`define DMAC_TRIG_CIPHER 8'h04
`define DMAC_TRIG_CONV_ONE 8'h10
`define DMAC_TRIG_CONV_TWO 8'h20
`define DMAC_TRIG_TMR_C0 8'h40
`define DMAC_TRIG_TMR_C1 8'h46
`define DMAC_TRIG_SPI_C 8'h4A
`define DMAC_TRIG_UART_C 8'h4B
`define DMAC_TRIG_TMR_E0 8'h80
`define DMAC_TRIG_UART_E 8'h8B

`endif

// file: src/dmac_pkg.sv
// Types shared by the DMA channel address, trigger and count block.
// Assumes the register header supplies all numeric constants.
package dmac_pkg;

  // Reload point of an address.
  typedef enum logic [1:0] {
    DMAC_RELOAD_NONE,
    DMAC_RELOAD_BLOCK,
    DMAC_RELOAD_BURST,
    DMAC_RELOAD_TRANS
  } dmac_reload_e;

  // Step mode of an address.
  typedef enum logic [1:0] {
    DMAC_STEP_FIXED,
    DMAC_STEP_INC,
    DMAC_STEP_DEC,
    DMAC_STEP_RSVD
  } dmac_step_e;

  // Register offset type.
  typedef logic [3:0] dmac_addr_t;

endpackage

// file: src/dmac_channel.sv
// Address stepping and reload, trigger select and block count of one
// DMA channel. Assumes the channel sequencer gives one-cycle pulses for
// transaction start, byte read, byte written, burst, block and
// transaction ends, and that requests come from other clock domains.
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "dmac_regs.svh"

module dmac_channel #(
  parameter bit HAS_CONV_TWO = 1'b1,
  parameter bit HAS_TMR_C1 = 1'b1,
  parameter bit HAS_TMR_E0 = 1'b1,
  parameter bit HAS_UART_E = 1'b1
) (
  input wire logic clock,
  input wire logic rst,
  input wire dmac_pkg::dmac_addr_t reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic trans_start,
  input wire logic channel_disable,
  input wire logic trans_complete,
  input wire logic error_set,
  input wire logic byte_read,
  input wire logic byte_written,
  input wire logic burst_end,
  input wire logic block_end,
  input wire logic trans_end,
  input wire logic [2:0] event_req,
  input wire logic cipher_req,
  input wire logic conv_one_req,
  input wire logic conv_two_req,
  input wire logic [5:0] timer_c0_req,
  input wire logic [3:0] timer_c1_req,
  input wire logic [5:0] timer_e0_req,
  input wire logic spi_c_req,
  input wire logic [1:0] uart_c_req,
  input wire logic [1:0] uart_e_req,
  output logic hw_trigger,
  output logic channel_busy_flag,
  output logic [15:0] source_address,
  output logic [15:0] dest_address,
  output logic [15:0] block_byte_count,
  output logic block_count_zero
);
  import dmac_pkg::*;

  // Request bus width: all peripheral request lines gathered together.
  localparam int REQ_W = 27;
  // Reset image of the address control register, sliced into its fields.
  localparam logic [7:0] CTRL_RST = `DMAC_RST_ADDR_CTRL;

  // Synchroniser stages for the asynchronous request lines.
  logic [REQ_W-1:0] req_meta_reg;
  logic [REQ_W-1:0] req_sync_reg;
  // Address control fields.
  dmac_reload_e source_reload_sel;
  dmac_step_e source_step_mode;
  dmac_reload_e dest_reload_sel;
  dmac_step_e dest_step_mode;
  // Trigger select register.
  logic [7:0] trigger_select;
  // Last value software wrote to the block count.
  logic [15:0] count_written_reg;
  // Initial addresses for reloading.
  logic [15:0] src_init_reg;
  logic [15:0] dst_init_reg;
  // Combinational selected request level.
  logic trig_next;

  // Raw request vector in a fixed layout.
  logic [REQ_W-1:0] req_raw;
  assign req_raw = {uart_e_req, uart_c_req, spi_c_req, timer_e0_req,
                    timer_c1_req, timer_c0_req, conv_two_req,
                    conv_one_req, cipher_req, event_req};

  // Steps an address by one in the given mode, wrapping at 16 bits.
  function automatic logic [15:0] step_addr(input logic [15:0] a,
                                            input dmac_step_e m);
    logic [15:0] r;
    r = a;
    unique case (m)
      DMAC_STEP_INC: r = a + 16'h0001;
      DMAC_STEP_DEC: r = a - 16'h0001;
      DMAC_STEP_FIXED: r = a;
      DMAC_STEP_RSVD: r = a;
    endcase
    return r;
  endfunction

  // True when the reload point of a field matches an end event.
  function automatic logic reload_hit(input dmac_reload_e s,
                                      input logic bu, input logic bl,
                                      input logic tr);
    logic h;
    h = 1'b0;
    unique case (s)
      DMAC_RELOAD_NONE: h = 1'b0;
      DMAC_RELOAD_BLOCK: h = bl;
      DMAC_RELOAD_BURST: h = bu;
      DMAC_RELOAD_TRANS: h = tr;
    endcase
    return h;
  endfunction

  // Two-stage synchroniser for every request line.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      req_meta_reg <= '0;
      req_sync_reg <= '0;
    end else begin
      req_meta_reg <= req_raw;
      req_sync_reg <= req_meta_reg;
    end
  end

  // Decodes trigger select as base plus offset into one request level.
  always_comb begin
    trig_next = 1'b0;
    // Code zero selects no request: software triggers only.
    if (trigger_select >= `DMAC_TRIG_EVENT &&
        trigger_select <= `DMAC_TRIG_EVENT + 8'h02) begin
      // Event channels at base plus zero to two.
      trig_next = req_sync_reg[2'(trigger_select - `DMAC_TRIG_EVENT)];
    end else if (trigger_select == `DMAC_TRIG_CIPHER) begin
      trig_next = req_sync_reg[3];
    end else if (trigger_select == `DMAC_TRIG_CONV_ONE) begin
      trig_next = req_sync_reg[4];
    end else if (trigger_select == `DMAC_TRIG_CONV_TWO) begin
      trig_next = HAS_CONV_TWO & req_sync_reg[5];
    end else if (trigger_select >= `DMAC_TRIG_TMR_C0 &&
                 trigger_select <= `DMAC_TRIG_TMR_C0 + 8'h05) begin
      // Type-0 timer has all six offsets.
      trig_next = req_sync_reg[6 + 3'(trigger_select - `DMAC_TRIG_TMR_C0)];
    end else if (trigger_select >= `DMAC_TRIG_TMR_C1 &&
                 trigger_select <= `DMAC_TRIG_TMR_C1 + 8'h03) begin
      // Type-1 timer stops at compare B.
      trig_next = HAS_TMR_C1 &
        req_sync_reg[12 + 2'(trigger_select - `DMAC_TRIG_TMR_C1)];
    end else if (trigger_select == `DMAC_TRIG_SPI_C) begin
      trig_next = req_sync_reg[22];
    end else if (trigger_select >= `DMAC_TRIG_TMR_E0 &&
                 trigger_select <= `DMAC_TRIG_TMR_E0 + 8'h05) begin
      trig_next = HAS_TMR_E0 &
        req_sync_reg[16 + 3'(trigger_select - `DMAC_TRIG_TMR_E0)];
    end else if (trigger_select >= `DMAC_TRIG_UART_C &&
                 trigger_select <= `DMAC_TRIG_UART_C + 8'h01) begin
      trig_next = req_sync_reg[23 + 1'(trigger_select - `DMAC_TRIG_UART_C)];
    end else if (trigger_select >= `DMAC_TRIG_UART_E &&
                 trigger_select <= `DMAC_TRIG_UART_E + 8'h01) begin
      trig_next = HAS_UART_E &
        req_sync_reg[25 + 1'(trigger_select - `DMAC_TRIG_UART_E)];
    end
    // Any other code is an absent module and stays low.
  end

  // Registers the selected request; the peripheral drops it on access.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hw_trigger <= 1'b0;
    end else begin
      hw_trigger <= trig_next;
    end
  end

  // Busy flag: set at transaction start, cleared on disable, done, error.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      channel_busy_flag <= 1'b0;
    end else if (trans_start) begin
      channel_busy_flag <= 1'b1;
    end else if (channel_disable || trans_complete || error_set) begin
      channel_busy_flag <= 1'b0;
    end
  end

  // Address control fields; all writes ignored while busy.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      source_reload_sel <= dmac_reload_e'(
        CTRL_RST[`DMAC_SRC_RELOAD_HI:`DMAC_SRC_RELOAD_LO]);
      source_step_mode <= dmac_step_e'(
        CTRL_RST[`DMAC_SRC_STEP_HI:`DMAC_SRC_STEP_LO]);
      dest_reload_sel <= dmac_reload_e'(
        CTRL_RST[`DMAC_DST_RELOAD_HI:`DMAC_DST_RELOAD_LO]);
      dest_step_mode <= dmac_step_e'(
        CTRL_RST[`DMAC_DST_STEP_HI:`DMAC_DST_STEP_LO]);
    end else if (reg_write && reg_addr == `DMAC_OFS_ADDR_CTRL &&
                 !channel_busy_flag) begin
      // Source reload write dropped when busy.
      source_reload_sel <= dmac_reload_e'(
        reg_wdata[`DMAC_SRC_RELOAD_HI:`DMAC_SRC_RELOAD_LO]);
      // Other fields frozen when busy.
      source_step_mode <= dmac_step_e'(
        reg_wdata[`DMAC_SRC_STEP_HI:`DMAC_SRC_STEP_LO]);
      dest_reload_sel <= dmac_reload_e'(
        reg_wdata[`DMAC_DST_RELOAD_HI:`DMAC_DST_RELOAD_LO]);
      dest_step_mode <= dmac_step_e'(
        reg_wdata[`DMAC_DST_STEP_HI:`DMAC_DST_STEP_LO]);
    end
  end

  // Trigger select register.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      trigger_select <= `DMAC_RST_TRIG_SEL;
    end else if (reg_write && reg_addr == `DMAC_OFS_TRIG_SEL) begin
      trigger_select <= reg_wdata;
    end
  end

  // Captures initial addresses when a transaction starts.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      src_init_reg <= `DMAC_RST_ADDR;
      dst_init_reg <= `DMAC_RST_ADDR;
    end else if (trans_start) begin
      src_init_reg <= source_address;
      dst_init_reg <= dest_address;
    end
  end

  // Source address: software write, reload, or step after a byte read.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      source_address <= `DMAC_RST_ADDR;
    end else if (reg_write && reg_addr == `DMAC_OFS_SRC_LOW) begin
      source_address[7:0] <= reg_wdata;
    end else if (reg_write && reg_addr == `DMAC_OFS_SRC_HIGH) begin
      source_address[15:8] <= reg_wdata;
    end else if (reload_hit(source_reload_sel, burst_end, block_end,
                            trans_end)) begin
      source_address <= src_init_reg;
    end else if (byte_read) begin
      source_address <= step_addr(source_address, source_step_mode);
    end
  end

  // Destination address: write, reload, or step after a byte written.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dest_address <= `DMAC_RST_ADDR;
    end else if (reg_write && reg_addr == `DMAC_OFS_DST_LOW) begin
      dest_address[7:0] <= reg_wdata;
    end else if (reg_write && reg_addr == `DMAC_OFS_DST_HIGH) begin
      dest_address[15:8] <= reg_wdata;
    end else if (reload_hit(dest_reload_sel, burst_end, block_end,
                            trans_end)) begin
      dest_address <= dst_init_reg;
    end else if (byte_written) begin
      dest_address <= step_addr(dest_address, dest_step_mode);
    end
  end

  // Last written block count, kept for reloading.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_written_reg <= `DMAC_RST_COUNT;
    end else if (reg_write && reg_addr == `DMAC_OFS_CNT_LOW) begin
      count_written_reg[7:0] <= reg_wdata;
    end else if (reg_write && reg_addr == `DMAC_OFS_CNT_HIGH) begin
      count_written_reg[15:8] <= reg_wdata;
    end
  end

  // Working block count: decrements per source byte, reloads at zero.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      block_byte_count <= `DMAC_RST_COUNT;
      block_count_zero <= 1'b0;
    end else if (reg_write && reg_addr == `DMAC_OFS_CNT_LOW) begin
      block_byte_count[7:0] <= reg_wdata;
      block_count_zero <= 1'b0;
    end else if (reg_write && reg_addr == `DMAC_OFS_CNT_HIGH) begin
      block_byte_count[15:8] <= reg_wdata;
      block_count_zero <= 1'b0;
    end else if (byte_read) begin
      if (block_byte_count == 16'h0001) begin
        // Reaching zero reloads the written value.
        block_byte_count <= count_written_reg;
        block_count_zero <= 1'b1;
      end else begin
        // Zero wraps to 0xFFFF, giving the long block.
        block_byte_count <= block_byte_count - 16'h0001;
        block_count_zero <= 1'b0;
      end
    end else begin
      block_count_zero <= 1'b0;
    end
  end

  // Read data, valid the cycle after the read strobe; unmapped reads zero.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      unique case (reg_addr)
        `DMAC_OFS_ADDR_CTRL: reg_rdata <= {source_reload_sel,
          source_step_mode, dest_reload_sel, dest_step_mode};
        `DMAC_OFS_TRIG_SEL: reg_rdata <= trigger_select;
        `DMAC_OFS_CNT_LOW: reg_rdata <= block_byte_count[7:0];
        `DMAC_OFS_CNT_HIGH: reg_rdata <= block_byte_count[15:8];
        `DMAC_OFS_SRC_LOW: reg_rdata <= source_address[7:0];
        `DMAC_OFS_SRC_HIGH: reg_rdata <= source_address[15:8];
        `DMAC_OFS_DST_LOW: reg_rdata <= dest_address[7:0];
        `DMAC_OFS_DST_HIGH: reg_rdata <= dest_address[15:8];
        `DMAC_OFS_STATUS: reg_rdata <= {6'h00, hw_trigger,
                                        channel_busy_flag};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Checks that stand beside the logic.
  default clocking dmac_cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence busy_write_s;
    reg_write && reg_addr == `DMAC_OFS_ADDR_CTRL && channel_busy_flag;
  endsequence

  a_busy_blocks_ctrl: assert property (
    busy_write_s |=> $stable(source_reload_sel))
    else $error("Source reload changed while busy.");
  a_busy_freezes_modes: assert property (
    busy_write_s |=> $stable({source_step_mode, dest_reload_sel,
                              dest_step_mode}))
    else $error("Address fields changed while busy.");
  a_trig_off_quiet: assert property (
    trigger_select == `DMAC_TRIG_OFF |=> !hw_trigger)
    else $error("Hardware trigger with select zero.");
  a_busy_sets_start: assert property (
    trans_start |=> channel_busy_flag)
    else $error("Busy not set at start.");
  a_busy_clears_done: assert property (
    !trans_start && (trans_complete || error_set) |=> !channel_busy_flag)
    else $error("Busy not cleared on completion.");
  a_count_decrements: assert property (
    byte_read && !reg_write && block_byte_count != 16'h0001
    |=> block_byte_count == $past(block_byte_count) - 16'h0001)
    else $error("Block count did not decrement.");
  a_count_reloads: assert property (
    byte_read && !reg_write && block_byte_count == 16'h0001
    |=> block_byte_count == count_written_reg && block_count_zero)
    else $error("Block count did not reload.");
  a_src_increments: assert property (
    byte_read && !reg_write && !burst_end && !block_end && !trans_end &&
    source_step_mode == DMAC_STEP_INC
    |=> source_address == $past(source_address) + 16'h0001)
    else $error("Source address did not increment.");
  a_src_block_reload: assert property (
    block_end && !reg_write && source_reload_sel == DMAC_RELOAD_BLOCK
    |=> source_address == src_init_reg)
    else $error("Source address not reloaded at block end.");
  a_absent_no_trig: assert property (
    trigger_select == 8'hFF |=> !hw_trigger)
    else $error("Trigger from an absent module code.");

endmodule

// file: dv/dmac_req_model.sv
// Behavioural model of the peripheral request sources facing the channel.
// Assumes the bench names the selected code and gives one-cycle pulses.
`timescale 1ns/1ps

module dmac_req_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] code,
  input wire logic raise,
  input wire logic access,
  input wire logic all_on,
  output logic [2:0] event_req,
  output logic cipher_req,
  output logic conv_one_req,
  output logic conv_two_req,
  output logic [5:0] timer_c0_req,
  output logic [3:0] timer_c1_req,
  output logic [5:0] timer_e0_req,
  output logic spi_c_req,
  output logic [1:0] uart_c_req,
  output logic [1:0] uart_e_req
);
  // Pending request of the peripheral that the code points at.
  logic pend_reg;

  // The request is withdrawn only by a data access, never by an interrupt.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pend_reg <= 1'b0;
    end else if (access) begin
      pend_reg <= 1'b0;
    end else if (raise) begin
      pend_reg <= 1'b1;
    end
  end

  // Each code lights the request at module base plus offset.
  always_comb begin
    event_req = {3{all_on}};
    cipher_req = all_on;
    conv_one_req = all_on;
    conv_two_req = all_on;
    timer_c0_req = {6{all_on}};
    timer_c1_req = {4{all_on}};
    timer_e0_req = {6{all_on}};
    spi_c_req = all_on;
    uart_c_req = {2{all_on}};
    uart_e_req = {2{all_on}};
    if (pend_reg) begin
      case (code)
        8'h01, 8'h02, 8'h03: event_req[code[1:0] - 2'h1] = 1'b1;
        8'h04: cipher_req = 1'b1;
        8'h10: conv_one_req = 1'b1;
        8'h20: conv_two_req = 1'b1;
        8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45: begin
          timer_c0_req[code[2:0]] = 1'b1;
        end
        8'h46, 8'h47, 8'h48, 8'h49: timer_c1_req[code[1:0] + 2'h2] = 1'b1;
        8'h4A: spi_c_req = 1'b1;
        8'h4B, 8'h4C: uart_c_req[~code[0]] = 1'b1;
        8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85: begin
          timer_e0_req[code[2:0]] = 1'b1;
        end
        8'h8B, 8'h8C: uart_e_req[~code[0]] = 1'b1;
        default: ;
      endcase
    end
  end
endmodule

// file: dv/dmac_channel_addr_trigger_count_test.sv
// Self-checking bench for the channel address, trigger and count block.
// Assumes the request model file and the design files are compiled first.
`timescale 1ns/1ps
`include "dmac_regs.svh"

module dmac_channel_addr_trigger_count_test;
  import dmac_pkg::*;
  // Sequencer pulse bits: start, disable, done, error, rd, wr, ends.
  localparam logic [8:0] P_START = 9'h100, P_DIS = 9'h080, P_DONE = 9'h040;
  localparam logic [8:0] P_ERR = 9'h020, P_RD = 9'h010, P_WR = 9'h008;
  localparam logic [8:0] P_BURST = 9'h004, P_BLOCK = 9'h002, P_TEND = 9'h001;
  logic clock, rst, reg_write, reg_read, raise, all_on, rd_seen;
  dmac_addr_t reg_addr;
  logic [7:0] reg_wdata, reg_rdata, mcode;
  logic [8:0] seq_v;
  logic [2:0] event_req;
  logic cipher_req, conv_one_req, conv_two_req, spi_c_req;
  logic [5:0] timer_c0_req, timer_e0_req;
  logic [3:0] timer_c1_req;
  logic [1:0] uart_c_req, uart_e_req;
  logic hw_trigger, channel_busy_flag, block_count_zero;
  logic [15:0] source_address, dest_address, block_byte_count, src0, dst0;
  logic [7:0] exp_q[$]; // Expected read bytes, oldest first.
  int fails = 0, checks = 0, cycles = 0;
  logic [7:0] trig_codes[27] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h10, 8'h20,
    8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47, 8'h48, 8'h49,
    8'h4A, 8'h4B, 8'h4C, 8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h8B,
    8'h8C};
  logic [7:0] dead_codes[7] = '{8'h00, 8'h05, 8'h11, 8'h4D, 8'h86, 8'h8D,
    8'hFF};

  dmac_channel DUT (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .trans_start(seq_v[8]),
    .channel_disable(seq_v[7]), .trans_complete(seq_v[6]),
    .error_set(seq_v[5]), .byte_read(seq_v[4]), .byte_written(seq_v[3]),
    .burst_end(seq_v[2]), .block_end(seq_v[1]), .trans_end(seq_v[0]),
    .event_req(event_req), .cipher_req(cipher_req),
    .conv_one_req(conv_one_req), .conv_two_req(conv_two_req),
    .timer_c0_req(timer_c0_req), .timer_c1_req(timer_c1_req),
    .timer_e0_req(timer_e0_req), .spi_c_req(spi_c_req),
    .uart_c_req(uart_c_req), .uart_e_req(uart_e_req),
    .hw_trigger(hw_trigger), .channel_busy_flag(channel_busy_flag),
    .source_address(source_address), .dest_address(dest_address),
    .block_byte_count(block_byte_count),
    .block_count_zero(block_count_zero));

  // The request model withdraws its request when the channel reads data.
  dmac_req_model u_req (.clock(clock), .rst(rst), .code(mcode),
    .raise(raise), .access(seq_v[4]), .all_on(all_on),
    .event_req(event_req), .cipher_req(cipher_req),
    .conv_one_req(conv_one_req), .conv_two_req(conv_two_req),
    .timer_c0_req(timer_c0_req), .timer_c1_req(timer_c1_req),
    .timer_e0_req(timer_e0_req), .spi_c_req(spi_c_req),
    .uart_c_req(uart_c_req), .uart_e_req(uart_e_req));

  // Free-running 125 MHz clock.
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle register write.
  task automatic wr(input dmac_addr_t a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  // Writes a 16-bit value as low byte then high byte.
  task automatic wr16(input dmac_addr_t a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 4'h1, v[15:8]);
  endtask

  // One-cycle register read; the expected byte waits in the queue.
  task automatic rd(input dmac_addr_t a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    exp_q.push_back(e);
    @(posedge clock);
    reg_read <= 1'b0;
  endtask

  // One-cycle sequencer pulse; returns once its effect has landed.
  task automatic seq(input logic [8:0] p);
    @(posedge clock);
    seq_v <= p;
    @(posedge clock);
    seq_v <= '0;
    #1;
  endtask

  // Waits whole cycles, then steps clear of the edge.
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Read data stand only in the cycle after the strobe.
  always @(posedge clock) begin
    rd_seen <= reg_read & ~rst;
    if (rd_seen === 1'b1) begin
      if (exp_q.size() == 0) begin
        check16({8'h00, reg_rdata}, 16'hDEAD);
      end else begin
        check16({8'h00, reg_rdata}, {8'h00, exp_q.pop_front()});
      end
    end
  end

  // Cuts a hang short.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      print_verdict();
    end
  end

  // Main sequence.
  initial begin
    rst = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    seq_v = '0;
    mcode = '0;
    raise = 1'b0;
    all_on = 1'b0;
    void'($urandom(32'h7ac555f5));
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    // Reset values and an unmapped offset.
    rd(`DMAC_OFS_ADDR_CTRL, `DMAC_RST_ADDR_CTRL);
    rd(`DMAC_OFS_TRIG_SEL, `DMAC_RST_TRIG_SEL);
    rd(`DMAC_OFS_CNT_LOW, 8'h01);
    rd(`DMAC_OFS_CNT_HIGH, 8'h00);
    rd(`DMAC_OFS_STATUS, 8'h00);
    rd(4'h0, 8'h00);
    // Increment and decrement with block and burst reloads.
    src0 = 16'($urandom);
    dst0 = 16'($urandom);
    wr16(`DMAC_OFS_SRC_LOW, src0);
    wr16(`DMAC_OFS_DST_LOW, dst0);
    wr(`DMAC_OFS_ADDR_CTRL, 8'h5A);
    seq(P_START);
    check16({15'h0, channel_busy_flag}, 16'h1);
    wr(`DMAC_OFS_ADDR_CTRL, 8'h00);
    rd(`DMAC_OFS_ADDR_CTRL, 8'h5A);
    repeat (3) seq(P_RD | P_WR);
    check16(source_address, src0 + 16'h3);
    check16(dest_address, dst0 - 16'h3);
    seq(P_BURST);
    check16(dest_address, dst0);
    check16(source_address, src0 + 16'h3);
    seq(P_BLOCK);
    check16(source_address, src0);
    seq(P_DONE);
    check16({15'h0, channel_busy_flag}, 16'h0);
    // Wrap at both ends, transaction reloads.
    wr16(`DMAC_OFS_SRC_LOW, 16'hFFFF);
    wr16(`DMAC_OFS_DST_LOW, 16'h0000);
    wr(`DMAC_OFS_ADDR_CTRL, 8'hDE);
    seq(P_START);
    seq(P_RD | P_WR);
    check16(source_address, 16'h0000);
    check16(dest_address, 16'hFFFF);
    seq(P_BLOCK);
    check16(source_address, 16'h0000);
    seq(P_TEND);
    check16(source_address, 16'hFFFF);
    check16(dest_address, 16'h0000);
    seq(P_ERR);
    check16({15'h0, channel_busy_flag}, 16'h0);
    // Reserved and fixed modes hold the addresses.
    wr(`DMAC_OFS_ADDR_CTRL, 8'h30);
    seq(P_START);
    seq(P_RD | P_WR);
    check16(source_address, 16'hFFFF);
    check16(dest_address, 16'h0000);
    seq(P_DIS);
    check16({15'h0, channel_busy_flag}, 16'h0);
    // Block count decrement, reload and the zero case.
    wr16(`DMAC_OFS_CNT_LOW, 16'h0003);
    seq(P_RD);
    check16(block_byte_count, 16'h0002);
    seq(P_RD);
    seq(P_RD);
    check16(block_byte_count, 16'h0003);
    check16({15'h0, block_count_zero}, 16'h1);
    wr16(`DMAC_OFS_CNT_LOW, 16'h0000);
    seq(P_RD);
    check16(block_byte_count, 16'hFFFF);
    // Every defined trigger code, raised and withdrawn.
    foreach (trig_codes[i]) begin
      wr(`DMAC_OFS_TRIG_SEL, trig_codes[i]);
      mcode <= trig_codes[i];
      @(posedge clock);
      raise <= 1'b1;
      @(posedge clock);
      raise <= 1'b0;
      rd(`DMAC_OFS_TRIG_SEL, trig_codes[i]);
      wait_cyc(4);
      check16({15'h0, hw_trigger}, 16'h1);
      seq(P_RD);
      wait_cyc(4);
      check16({15'h0, hw_trigger}, 16'h0);
    end
    // Off and undefined codes never trigger, whatever is requested.
    all_on <= 1'b1;
    foreach (dead_codes[i]) begin
      wr(`DMAC_OFS_TRIG_SEL, dead_codes[i]);
      wait_cyc(5);
      check16({15'h0, hw_trigger}, 16'h0);
    end
    all_on <= 1'b0;
    wait_cyc(3);
    check16(16'(exp_q.size()), 16'h0);
    print_verdict();
  end
endmodule
